// ---- rtl/pmsc_consts.svh ----
// pmsc_consts.svh: offsets, field positions and reset values of the power block
// assumes: included by bare name from the design file only
`ifndef PMSC_CONSTS_SVH
`define PMSC_CONSTS_SVH

// register byte offsets on the apb bus
`define PMSC_OFF_CTL1 8'h00
`define PMSC_OFF_CTL2 8'h04
`define PMSC_OFF_STS 8'h08
`define PMSC_OFF_MASK 8'h0C

// power_detect_control fields
`define PMSC_C1_FLAG 7
`define PMSC_C1_ACK 6
`define PMSC_C1_IRQ_EN 5
`define PMSC_C1_RST_EN 4
`define PMSC_C1_STOP_EN 3
`define PMSC_C1_EN 2

// power_warning_powerdown_control fields
`define PMSC_C2_WFLAG 7
`define PMSC_C2_WACK 6
`define PMSC_C2_DTRIP 5
`define PMSC_C2_WTRIP 4
`define PMSC_C2_PFLAG 3
`define PMSC_C2_PACK 2
`define PMSC_C2_PD_EN 1
`define PMSC_C2_PSEL 0

// event status layout, shared by status and mask
`define PMSC_EV_W 3
`define PMSC_EV_DETECT 0
`define PMSC_EV_WARN 1
`define PMSC_EV_PPD 2
`define PMSC_STS_STATE_LO 4

// reset values
`define PMSC_C1_RESET 4'h7
`define PMSC_EV_RESET 3'h0

`endif

// ---- rtl/pmsc_pkg.sv ----
// pmsc_pkg: types shared by the power management status and control block
// assumes: constants come from pmsc_consts.svh
package pmsc_pkg;

  // stop state, gray coded along run -> stop -> full -> partial
  typedef enum logic [1:0] {
    PMSC_RUN = 2'h0,
    PMSC_STOP = 2'h1,
    PMSC_PD_FULL = 2'h3,
    PMSC_PD_PART = 2'h2
  } pmsc_state_e;

  typedef enum logic [2:0] {
    PMSC_SEL_CTL1 = 3'h0,
    PMSC_SEL_CTL2 = 3'h1,
    PMSC_SEL_STS = 3'h2,
    PMSC_SEL_MASK = 3'h3,
    PMSC_SEL_NONE = 3'h4
  } pmsc_sel_e;

  // software controls of the detect register
  typedef struct packed {
    logic irq_en;
    logic reset_en;
    logic stop_en;
    logic en;
  } pmsc_ctl1_s;

  // analog comparator outputs, high while the supply is below the trip
  typedef struct packed {
    logic detect_below_low;
    logic detect_below_high;
    logic warn_below_low;
    logic warn_below_high;
  } pmsc_cmp_s;

endpackage

// ---- rtl/pmsc_top.sv ----
// pmsc_top: power management status and control, apb slave, low-voltage flags
// assumes: comparators are synchronous to pclk, por_n is low only at power-on
// How it works
// - detect flag bit 7 sets on a detect event while detection is enabled
// - writing 1 to bit 6 clears the detect flag; bit 6 reads 0
// - bit 5 set raises an interrupt while the detect flag is set
// - bit 4 and enable force chip reset while the detect flag is set
// - bit 3 keeps detection running in stop, otherwise stop disables it
// - bit 2 turns detection on and qualifies flag, reset and stop bits
// - write-once bits accept only the first write after any reset
// - warning flag sets when supply below warning trip, also after reset
// - warning ack clears the warning flag only if no warning is present
// - bit 5 of second register picks low or high detect trip point
// - bit 4 picks low warning trip at 0, high at 1
// - partial power down flag sets on exit from partial power down
// - writing 1 to bit 2 clears the partial power down flag
// - write-once bit 1 enables power down stop modes when set
// - write-once bit 0 picks partial over full power down when enabled
// - power-on reset clears all; other resets keep both trip selects
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "pmsc_consts.svh"

module pmsc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pmsc_pkg::pmsc_cmp_s cmp,
  input wire logic stop_req,
  input wire logic wake_evt,
  output logic irq,
  output logic lowv_reset,
  output logic detect_active,
  output logic detect_trip_select,
  output logic warning_trip_select,
  output pmsc_pkg::pmsc_state_e stop_mode
);

  function automatic pmsc_pkg::pmsc_sel_e reg_sel(input logic [7:0] a);
    case (a)
      `PMSC_OFF_CTL1: reg_sel = pmsc_pkg::PMSC_SEL_CTL1;
      `PMSC_OFF_CTL2: reg_sel = pmsc_pkg::PMSC_SEL_CTL2;
      `PMSC_OFF_STS: reg_sel = pmsc_pkg::PMSC_SEL_STS;
      `PMSC_OFF_MASK: reg_sel = pmsc_pkg::PMSC_SEL_MASK;
      default: reg_sel = pmsc_pkg::PMSC_SEL_NONE;
    endcase
  endfunction

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  pmsc_pkg::pmsc_ctl1_s ctl1_q;
  logic det_flag_q;
  logic wo1_done_q;
  logic wo2_done_q;
  logic det_trip_q;
  logic warn_trip_q;
  logic warn_flag_q;
  logic ppd_flag_q;
  logic pd_en_q;
  logic ppd_sel_q;
  logic [`PMSC_EV_W-1:0] sts_q;
  logic [`PMSC_EV_W-1:0] mask_q;
  logic [`PMSC_EV_W-1:0] ev;
  pmsc_pkg::pmsc_state_e state_q;
  logic irq_q;
  logic lowv_reset_q;
  logic det_active_q;
  pmsc_pkg::pmsc_ctl1_s ctl1_d;
  logic wo1_done_d;
  logic det_flag_d;
  logic warn_flag_d;
  logic ppd_flag_d;
  logic det_trip_d;
  logic warn_trip_d;
  logic pd_en_d;
  logic ppd_sel_d;
  logic wo2_done_d;
  logic [`PMSC_EV_W-1:0] mask_d;
  pmsc_pkg::pmsc_state_e state_d;
  logic irq_d;
  logic lowv_reset_d;

  logic access;
  logic done;
  logic wr;
  logic rd;
  pmsc_pkg::pmsc_sel_e sel;
  logic wr_ctl1;
  logic wr_ctl2;
  logic rd_sts;
  logic det_active;
  logic det_cmp;
  logic det_set;
  logic det_ack;
  logic warn_cmp;
  logic warn_ack;
  logic ppd_exit;
  logic ppd_ack;
  logic [7:0] ctl1_view;
  logic [7:0] ctl2_view;
  logic [31:0] rd_mux;

  // one wait state: pready rises in the second access cycle, writes land there
  assign access = psel & penable;
  assign done = access & pready_q;
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;
  assign sel = reg_sel(paddr);
  assign wr_ctl1 = wr & (sel == pmsc_pkg::PMSC_SEL_CTL1);
  assign wr_ctl2 = wr & (sel == pmsc_pkg::PMSC_SEL_CTL2);
  assign rd_sts = rd & (sel == pmsc_pkg::PMSC_SEL_STS);

  // detection runs in run mode, and in any stop mode only if stop enable is set
  assign det_active = ctl1_q.en & ((state_q == pmsc_pkg::PMSC_RUN) | ctl1_q.stop_en);
  assign det_cmp = det_trip_q ? cmp.detect_below_high : cmp.detect_below_low;
  assign det_set = det_active & det_cmp;
  assign det_ack = wr_ctl1 & pwdata[`PMSC_C1_ACK];
  assign warn_cmp = warn_trip_q ? cmp.warn_below_high : cmp.warn_below_low;
  assign warn_ack = wr_ctl2 & pwdata[`PMSC_C2_WACK];
  assign ppd_ack = wr_ctl2 & pwdata[`PMSC_C2_PACK];
  assign ppd_exit = (state_q == pmsc_pkg::PMSC_PD_PART) & wake_evt;

  assign ctl1_view = {det_flag_q, 1'b0, ctl1_q.irq_en, ctl1_q.reset_en,
                      ctl1_q.stop_en, ctl1_q.en, 2'b00};
  assign ctl2_view = {warn_flag_q, 1'b0, det_trip_q, warn_trip_q,
                      ppd_flag_q, 1'b0, pd_en_q, ppd_sel_q};

  always_comb begin
    case (sel)
      pmsc_pkg::PMSC_SEL_CTL1: rd_mux = {24'h000000, ctl1_view};
      pmsc_pkg::PMSC_SEL_CTL2: rd_mux = {24'h000000, ctl2_view};
      pmsc_pkg::PMSC_SEL_STS: rd_mux = {26'h0000000, state_q, 1'b0, sts_q};
      pmsc_pkg::PMSC_SEL_MASK: rd_mux = {29'h00000000, mask_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // read data is captured a cycle early so prdata already stands with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & (sel == pmsc_pkg::PMSC_SEL_NONE);
      if (access & ~pready_q & ~pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // irq enable stays writable; the stop, reset and enable qualifiers lock once
  always_comb begin
    ctl1_d = ctl1_q;
    wo1_done_d = wo1_done_q;
    if (wr_ctl1) begin
      ctl1_d.irq_en = pwdata[`PMSC_C1_IRQ_EN];
      wo1_done_d = 1'b1;
      if (!wo1_done_q) begin
        ctl1_d.reset_en = pwdata[`PMSC_C1_RST_EN];
        ctl1_d.stop_en = pwdata[`PMSC_C1_STOP_EN];
        ctl1_d.en = pwdata[`PMSC_C1_EN];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_q <= `PMSC_C1_RESET;
      wo1_done_q <= 1'b0;
    end else begin
      ctl1_q <= ctl1_d;
      wo1_done_q <= wo1_done_d;
    end
  end

  // each set term is applied after its clear, so an event wins over the ack
  always_comb begin
    det_flag_d = det_flag_q;
    warn_flag_d = warn_flag_q;
    ppd_flag_d = ppd_flag_q;
    if (det_ack | ~ctl1_q.en) begin
      det_flag_d = 1'b0;
    end
    if (det_set) begin
      det_flag_d = 1'b1;
    end
    if (warn_ack) begin
      warn_flag_d = 1'b0;
    end
    if (warn_cmp) begin
      warn_flag_d = 1'b1;
    end
    if (ppd_ack) begin
      ppd_flag_d = 1'b0;
    end
    if (ppd_exit) begin
      ppd_flag_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_flag_q <= 1'b0;
    end else begin
      det_flag_q <= det_flag_d;
    end
  end

  // warning flag sets from the comparator from the first cycle after reset and holds until acked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_flag_q <= 1'b0;
    end else begin
      warn_flag_q <= warn_flag_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ppd_flag_q <= 1'b0;
    end else begin
      ppd_flag_q <= ppd_flag_d;
    end
  end

  // trip selects follow every write; power down controls lock after the first
  always_comb begin
    det_trip_d = det_trip_q;
    warn_trip_d = warn_trip_q;
    pd_en_d = pd_en_q;
    ppd_sel_d = ppd_sel_q;
    wo2_done_d = wo2_done_q;
    if (wr_ctl2) begin
      det_trip_d = pwdata[`PMSC_C2_DTRIP];
      warn_trip_d = pwdata[`PMSC_C2_WTRIP];
      wo2_done_d = 1'b1;
      if (!wo2_done_q) begin
        pd_en_d = pwdata[`PMSC_C2_PD_EN];
        ppd_sel_d = pwdata[`PMSC_C2_PSEL];
      end
    end
  end

  // trip selects survive every reset but power-on, so they sit on por_n alone
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      det_trip_q <= 1'b0;
      warn_trip_q <= 1'b0;
    end else begin
      det_trip_q <= det_trip_d;
      warn_trip_q <= warn_trip_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_en_q <= 1'b0;
      ppd_sel_q <= 1'b0;
      wo2_done_q <= 1'b0;
    end else begin
      pd_en_q <= pd_en_d;
      ppd_sel_q <= ppd_sel_d;
      wo2_done_q <= wo2_done_d;
    end
  end

  // stop entry picks a power down mode only when power down is enabled
  always_comb begin
    state_d = state_q;
    case (state_q)
      pmsc_pkg::PMSC_RUN: begin
        if (stop_req) begin
          if (!pd_en_q) begin
            state_d = pmsc_pkg::PMSC_STOP;
          end else if (ppd_sel_q) begin
            state_d = pmsc_pkg::PMSC_PD_PART;
          end else begin
            state_d = pmsc_pkg::PMSC_PD_FULL;
          end
        end
      end
      pmsc_pkg::PMSC_STOP,
      pmsc_pkg::PMSC_PD_FULL,
      pmsc_pkg::PMSC_PD_PART: begin
        if (wake_evt) begin
          state_d = pmsc_pkg::PMSC_RUN;
        end
      end
      default: state_d = pmsc_pkg::PMSC_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pmsc_pkg::PMSC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  assign ev[`PMSC_EV_DETECT] = det_set & ~det_flag_q;
  assign ev[`PMSC_EV_WARN] = warn_cmp & ~warn_flag_q;
  assign ev[`PMSC_EV_PPD] = ppd_exit;

  // sticky event bits; a new event in the clearing read's cycle survives it
  genvar gi;
  generate
    for (gi = 0; gi < `PMSC_EV_W; gi = gi + 1) begin : g_sts
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sts_q[gi] <= 1'b0;
        end else begin
          sts_q[gi] <= ev[gi] | (sts_q[gi] & ~rd_sts);
        end
      end
    end
  endgenerate

  // mask writes take the low event bits only; upper data bits are dropped
  always_comb begin
    mask_d = mask_q;
    if (wr & (sel == pmsc_pkg::PMSC_SEL_MASK)) begin
      mask_d = pwdata[`PMSC_EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `PMSC_EV_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // the detect request is a level on the flag, so it holds until acked
  always_comb begin
    irq_d = (|(sts_q & mask_q)) | (det_flag_q & ctl1_q.irq_en);
    lowv_reset_d = det_flag_q & ctl1_q.reset_en & ctl1_q.en;
  end

  // outputs leave from flops so the chip reset request never glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      lowv_reset_q <= 1'b0;
      det_active_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      lowv_reset_q <= lowv_reset_d;
      det_active_q <= det_active;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign lowv_reset = lowv_reset_q;
  assign detect_active = det_active_q;
  assign detect_trip_select = det_trip_q;
  assign warning_trip_select = warn_trip_q;
  assign stop_mode = state_q;

endmodule

// ---- verification/pmsc_props.sv ----
// pmsc_props: port-level checks for the power management block
// assumes: bound into pmsc_top, one pclk domain, presetn async low
`timescale 1ns/1ps
module pmsc_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_req,
  input wire logic wake_evt,
  input wire logic detect_trip_select,
  input wire logic warning_trip_select,
  input wire pmsc_pkg::pmsc_state_e stop_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_second_access: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_error: assert property (pready && paddr > 8'h0C |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (pready && paddr <= 8'h0C && paddr[1:0] == 0 |-> !pslverr)
    else $error("mapped access refused");
  a_detect_ack_zero: assert property (pready && !pwrite && paddr == 8'h00 |-> !prdata[6])
    else $error("detect ack reads nonzero");
  a_other_acks_zero: assert property (pready && !pwrite && paddr == 8'h04 |-> !prdata[6] && !prdata[2])
    else $error("warning or partial ack reads nonzero");
  a_trip_by_write: assert property ($changed({detect_trip_select, warning_trip_select}) |->
    $past(pready && pwrite && paddr == 8'h04)) else $error("trip select moved without write");
  a_wake_to_run: assert property (stop_mode != pmsc_pkg::PMSC_RUN && wake_evt |=> stop_mode == pmsc_pkg::PMSC_RUN)
    else $error("wake did not return to run");
  a_stop_leaves_run: assert property (stop_mode == pmsc_pkg::PMSC_RUN && stop_req && !wake_evt |=>
    stop_mode != pmsc_pkg::PMSC_RUN) else $error("stop request ignored");
  c_part: cover property (stop_mode == pmsc_pkg::PMSC_PD_PART);
  c_err: cover property (pready && pslverr);
  c_trip: cover property ($rose(warning_trip_select));
endmodule
bind pmsc_top pmsc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .stop_req, .wake_evt, .detect_trip_select, .warning_trip_select, .stop_mode);

// ---- verification/pmsc_tb_top.sv ----
// pmsc_tb_top: self-checking bench, apb master and comparator stimulus
// assumes: pmsc_top and pmsc_props compiled first
`timescale 1ns/1ps
module pmsc_tb_top;
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic stop_req = 0, wake_evt = 0, pready, pslverr, irq, lowv_reset, rerr;
  logic detect_active, detect_trip_select, warning_trip_select;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  pmsc_pkg::pmsc_cmp_s cmp = '0;
  pmsc_pkg::pmsc_state_e stop_mode;
  int n_fail = 0, checks = 0;
  always #4 pclk = ~pclk;
  pmsc_top dut_u (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cmp, .stop_req, .wake_evt, .irq, .lowv_reset, .detect_active,
    .detect_trip_select, .warning_trip_select, .stop_mode);
  task chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(int k);
    repeat (k) @(negedge pclk);
  endtask
  // upper data bits are random: only the low byte may matter
  task apb(logic w, logic [7:0] a, logic [7:0] d);
    logic [31:0] r;
    int k;
    r = $urandom();
    k = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {r[23:0], d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdat = prdata;
    rerr = pslverr;
    if (k >= 20) chk("pready", 0, 1);
    psel <= 0;
    penable <= 0;
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    apb(0, a, 8'h00);
    chk("prdata", rdat, e);
  endtask
  task drv(logic [3:0] c, logic s, logic w);
    @(posedge pclk);
    cmp <= c;
    stop_req <= s;
    wake_evt <= w;
  endtask
  task rst(logic p);
    @(posedge pclk);
    presetn <= 0;
    por_n <= p;
    cyc(2);
    @(posedge pclk);
    presetn <= 1;
    por_n <= 1;
  endtask
  task results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    results();
  end
  initial begin
    void'($urandom(20));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    por_n <= 1;
    rd(8'h00, 32'h1C);
    rd(8'h04, 32'h00);
    rd(8'h10, 32'h00);
    chk("pslverr", rerr, 1);
    $display("test reset done");
    drv(4'h8, 0, 0);
    cyc(3);
    chk("lowv_reset", lowv_reset, 1);
    drv(4'h0, 0, 0);
    rd(8'h00, 32'h9C);
    apb(1, 8'h00, 8'h3C);
    cyc(2);
    chk("irq", irq, 1);
    apb(1, 8'h00, 8'h40);
    rd(8'h00, 32'h1C);
    chk("irq", irq, 0);
    chk("lowv_reset", lowv_reset, 0);
    apb(1, 8'h0C, 8'h07);
    cyc(2);
    chk("irq", irq, 1);
    rd(8'h08, 32'h01);
    cyc(2);
    chk("irq", irq, 0);
    $display("test detect done");
    apb(1, 8'h04, 8'h33);
    cyc(1);
    chk("trips", {detect_trip_select, warning_trip_select}, 2'b11);
    drv(4'hA, 0, 0);
    cyc(3);
    rd(8'h00, 32'h1C);
    rd(8'h04, 32'h33);
    drv(4'h1, 0, 0);
    cyc(3);
    chk("irq", irq, 1);
    apb(1, 8'h04, 8'h70);
    rd(8'h04, 32'hB3);
    drv(4'h0, 0, 0);
    apb(1, 8'h04, 8'h70);
    rd(8'h04, 32'h33);
    rd(8'h08, 32'h02);
    $display("test warning done");
    drv(4'h0, 1, 0);
    drv(4'h0, 0, 0);
    cyc(1);
    chk("stop_mode", stop_mode, pmsc_pkg::PMSC_PD_PART);
    chk("detect_active", detect_active, 1);
    drv(4'h0, 0, 1);
    drv(4'h0, 0, 0);
    cyc(1);
    chk("stop_mode", stop_mode, pmsc_pkg::PMSC_RUN);
    rd(8'h04, 32'h3B);
    apb(1, 8'h04, 8'h34);
    rd(8'h04, 32'h33);
    rd(8'h08, 32'h04);
    $display("test stop done");
    drv(4'h1, 0, 0);
    rst(1);
    rd(8'h04, 32'hB0);
    drv(4'h0, 0, 0);
    rst(0);
    rd(8'h04, 32'h00);
    apb(1, 8'h00, 8'h00);
    rd(8'h00, 32'h00);
    chk("detect_active", detect_active, 0);
    drv(4'h0, 1, 0);
    drv(4'h0, 0, 0);
    cyc(1);
    chk("stop_mode", stop_mode, pmsc_pkg::PMSC_STOP);
    drv(4'h0, 0, 1);
    drv(4'h0, 0, 0);
    apb(1, 8'h04, 8'h02);
    drv(4'h0, 1, 0);
    drv(4'h0, 0, 0);
    cyc(1);
    chk("stop_mode", stop_mode, pmsc_pkg::PMSC_PD_FULL);
    drv(4'h0, 0, 1);
    drv(4'h0, 0, 0);
    rd(8'h04, 32'h02);
    $display("test resets done");
    results();
  end
endmodule
